// ---- jtc_dbg_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module jtc_dbg_model (
   input wire logic ref_clk_in,
   input wire logic tdo_in,
   input wire logic tdo_oe_n_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   output logic trst_n_out
);
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
      // test reset low at power up
      trst_n_out = 1'b0;
      repeat (10) @(posedge ref_clk_in);
      trst_n_out <= 1'b1;
   end

   task set_trst(input logic v);
      @(posedge ref_clk_in);
      trst_n_out <= v;
   endtask : set_trst

   ////////////////////////////////////////////////////////////////
   // one tck period; tck stands low between bits
   task bit_cyc(input logic m, input logic d, output logic q);
      @(posedge ref_clk_in);
      tms_out <= m;
      tdi_out <= d;
      repeat (4) @(posedge ref_clk_in);
      tck_out <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      // released line read as the inverse of the held level
      q = tdo_oe_n_in ? ~tdo_in : tdo_in;
      tck_out <= 1'b0;
   endtask : bit_cyc

   // from run-test-idle through capture, shift and update back to idle
   task scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
      logic q;
      dout = '0;
      bit_cyc(1'b1, 1'b0, q);
      if (ir) bit_cyc(1'b1, 1'b0, q);
      bit_cyc(1'b0, 1'b0, q);
      bit_cyc(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         bit_cyc(i == n - 1, din[i], q);
         dout[i] = q;
      end
      // data line driven to the inverse of the last bit
      bit_cyc(1'b1, ~din[n-1], q);
      bit_cyc(1'b0, ~din[n-1], q);
   endtask : scan
endmodule : jtc_dbg_model

`default_nettype wire

// ---- jtc_map.svh ----
`ifndef JTC_MAP_SVH
`define JTC_MAP_SVH

// instruction register
`define JTC_IR_W 4
`define JTC_IR_CAPTURE 4'h1
`define JTC_OP_EXTEST 4'h0
`define JTC_OP_DEVICE_IDENTIFICATION_WORD 4'h1
`define JTC_OP_USERCODE 4'h2
`define JTC_OP_CORE 4'h3
`define JTC_OP_SAMPLE 4'h4
`define JTC_OP_BYPASS 4'hf

// data register lengths
`define JTC_DR_W 34
`define JTC_LEN_BYP 6'd1
`define JTC_LEN_WORD 6'd32
`define JTC_LEN_CORE 6'd34

// identification word layout
`define JTC_ID_ONE 1'b1
`define JTC_UC_UNUSED 6'h00

// security word fields
`define JTC_SEC_JTAG_DIS 0
`define JTC_SEC_OTP_DIS 13
`define JTC_SEC_UID_HI 31
`define JTC_SEC_UID_LO 22
`define JTC_SEC_RESET 32'h0000_0000

// core access targets
`define JTC_TGT_TILE 2'h0
`define JTC_TGT_SWITCH 2'h1
`define JTC_TGT_OTP 2'h2

`endif

// ---- jtc_pkg.sv ----
package jtc_pkg;

   typedef enum logic [15:0] {
      TAP_TLR = 16'h0001,
      TAP_RTI = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SH_DR = 16'h0010,
      TAP_EX1_DR = 16'h0020,
      TAP_PA_DR = 16'h0040,
      TAP_EX2_DR = 16'h0080,
      TAP_UPD_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SH_IR = 16'h0800,
      TAP_EX1_IR = 16'h1000,
      TAP_PA_IR = 16'h2000,
      TAP_EX2_IR = 16'h4000,
      TAP_UPD_IR = 16'h8000
   } jtc_tap_t;

   typedef logic [1:0] jtc_target_t;

endpackage : jtc_pkg

// ---- jtc_sec_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "jtc_map.svh"

module jtc_sec_mem (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic load_in,
   input wire logic [31:0] word_in,
   output logic [31:0] word_out
);
   import jtc_pkg::*;

   typedef struct packed {
      logic [31:0] mem;
      logic [31:0] rd;
   } jtc_sec_st_t;

   jtc_sec_st_t st_q, st_d;

   // word loaded from otp at power up, read copy registered
   always_comb begin
      st_d = st_q;
      if (load_in) begin
         st_d.mem = word_in;
      end
      st_d.rd = st_q.mem;
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         st_q <= '{mem: `JTC_SEC_RESET, rd: `JTC_SEC_RESET};
      end else begin
         st_q <= st_d;
      end
   end

   assign word_out = st_q.rd;

endmodule : jtc_sec_mem
`default_nettype wire

// ---- jtc_tap_chain.sv ----
// Function
// RQ1 - after reset the chain holds a boundary-scan TAP and a core-access TAP
// RQ2 - boundary-scan TAP follows 1149.1 and scans the I/O pins
// RQ3 - core-access TAP reaches tile, switch and OTP for code load and debug
// RQ4 - board holds test reset low at power up and 100 ns after
// RQ5 - test reset held low keeps the whole JTAG logic in reset; code resets only the TAP state, both instructions and the TDO enable
// RQ6 - DEVICE_IDENTIFICATION_WORD selects a 32-bit identification word with bit 0 one
// RQ7 - USERCODE selects a 32-bit word: user ID, unused, silicon revision
// RQ8 - user ID comes from security bits 31..22, zero when unprogrammed
// RQ9 - active-low global reset resets everything without a clock; code does not reset the security word store, which only reset_in clears
// RQ10 - after global reset wait for PLL lock, then boot by boot mode
// RQ11 - board holds global reset low at power up and 100 ns after
// RQ12 - security bits 31..22 hold the user ID extension read by USERCODE
// RQ13 - security bit 0 set disables JTAG access to tile state
// RQ14 - ID word: version 31:28, part 27:12, maker 11:1, one in bit 0
`timescale 1ns/100ps
`default_nettype none
`include "jtc_map.svh"

module jtc_tap_chain #(
   parameter int NUM_IO = 16,
   // identity values below are arbitrary
   parameter logic [3:0] ID_VERSION = 4'h0,
   parameter logic [15:0] ID_PART = 16'h0001,
   parameter logic [10:0] ID_MAKER = 11'h001,
   parameter logic [15:0] SILICON_REV = 16'h0001
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic glob_rst_n_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   input wire logic trst_n_in,
   input wire logic pll_lock_in,
   input wire logic [1:0] boot_mode_in,
   input wire logic [NUM_IO-1:0] io_pin_in,
   input wire logic sec_load_in,
   input wire logic [31:0] sec_word_in,
   input wire logic [31:0] core_rdata_in,
   output logic tdo_out,
   output logic tdo_oe_n_out,
   output logic bs_mode_out,
   output logic [NUM_IO-1:0] bs_pin_out,
   output logic core_wr_out,
   output logic core_rd_out,
   output jtc_pkg::jtc_target_t core_sel_out,
   output logic [31:0] core_wdata_out,
   output logic boot_start_out,
   output logic [1:0] boot_mode_out
);
   import jtc_pkg::*;

   typedef struct packed {
      logic [1:0] tck_s;
      logic tck_d;
      logic [1:0] tms_s;
      logic [1:0] tdi_s;
      logic [1:0] trst_s;
      logic [1:0] lock_s;
      logic [1:0] boot_s0;
      logic [1:0] boot_s1;
      logic [NUM_IO-1:0] io_s0;
      logic [NUM_IO-1:0] io_s1;
      jtc_tap_t tap;
      logic [`JTC_IR_W-1:0] ir_bs;
      logic [`JTC_IR_W-1:0] ir_ca;
      logic [`JTC_IR_W-1:0] irs_bs;
      logic [`JTC_IR_W-1:0] irs_ca;
      logic [`JTC_DR_W-1:0] dr_bs;
      logic [`JTC_DR_W-1:0] dr_ca;
      logic tdo;
      logic tdo_oe_n;
      logic bs_mode;
      logic [NUM_IO-1:0] bs_pin;
      logic core_wr;
      logic core_rd;
      jtc_target_t core_sel;
      logic [31:0] core_wdata;
      logic boot_start;
      logic [1:0] boot_mode;
   } jtc_state_t;

   localparam jtc_state_t ST_RST = '{
      tap: TAP_TLR,
      ir_bs: `JTC_OP_DEVICE_IDENTIFICATION_WORD,
      ir_ca: `JTC_OP_DEVICE_IDENTIFICATION_WORD,
      tdo_oe_n: 1'b1,
      default: '0
   };

   jtc_state_t st_q, st_d;
   logic [31:0] sec_word;
   logic locked;
   logic tck_rise;
   logic tck_fall;
   logic [`JTC_IR_W-1:0] ins_bs;
   logic [`JTC_IR_W-1:0] ins_ca;
   logic [31:0] id_word;
   logic [31:0] user_word;

   ////////////////////////////////////////////////////////////////////////////
   // security word store

   jtc_sec_mem u_sec (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .load_in(sec_load_in),
      .word_in(sec_word_in),
      .word_out(sec_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic jtc_tap_t jtc_tap_next(input jtc_tap_t s, input logic tms);
      unique case (s)
         TAP_TLR: return tms ? TAP_TLR : TAP_RTI;
         TAP_RTI: return tms ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_DR: return tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: return tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: return tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: return tms ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR: return tms ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: return tms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: return tms ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_IR: return tms ? TAP_TLR : TAP_CAP_IR;
         TAP_CAP_IR: return tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: return tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: return tms ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR: return tms ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: return tms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: return tms ? TAP_SEL_DR : TAP_RTI;
         default: return TAP_TLR;
      endcase
   endfunction : jtc_tap_next

   // length of the register selected by an instruction
   function automatic logic [5:0] jtc_dr_len(input logic [`JTC_IR_W-1:0] ins);
      unique case (ins)
         `JTC_OP_DEVICE_IDENTIFICATION_WORD, `JTC_OP_USERCODE: return `JTC_LEN_WORD;
         `JTC_OP_CORE: return `JTC_LEN_CORE;
         `JTC_OP_EXTEST, `JTC_OP_SAMPLE: return 6'(NUM_IO);
         default: return `JTC_LEN_BYP;
      endcase
   endfunction : jtc_dr_len

   // shift right, new bit enters at the top of the selected length
   function automatic logic [`JTC_DR_W-1:0] jtc_shift(input logic [`JTC_DR_W-1:0] v,
                                                      input logic b, input logic [5:0] len);
      logic [`JTC_DR_W-1:0] r;
      r = v >> 1;
      r[len - 6'd1] = b;
      return r;
   endfunction : jtc_shift

   ////////////////////////////////////////////////////////////////////////////
   // decode

   // RQ13 jtag disable bit
   assign locked = sec_word[`JTC_SEC_JTAG_DIS];
   assign tck_rise = st_q.tck_s[1] & ~st_q.tck_d;
   assign tck_fall = ~st_q.tck_s[1] & st_q.tck_d;
   assign ins_bs = locked ? `JTC_OP_BYPASS : st_q.ir_bs;
   assign ins_ca = locked ? `JTC_OP_BYPASS : st_q.ir_ca;
   // RQ14 id word layout
   assign id_word = {ID_VERSION, ID_PART, ID_MAKER, `JTC_ID_ONE};
   // RQ8 RQ12 user id from security bits
   assign user_word = {sec_word[`JTC_SEC_UID_HI:`JTC_SEC_UID_LO], `JTC_UC_UNUSED, SILICON_REV};

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_d = st_q;
      st_d.tck_s = {st_q.tck_s[0], tck_in};
      st_d.tck_d = st_q.tck_s[1];
      st_d.tms_s = {st_q.tms_s[0], tms_in};
      st_d.tdi_s = {st_q.tdi_s[0], tdi_in};
      st_d.trst_s = {st_q.trst_s[0], trst_n_in};
      st_d.lock_s = {st_q.lock_s[0], pll_lock_in};
      st_d.boot_s0 = boot_mode_in;
      st_d.boot_s1 = st_q.boot_s0;
      st_d.io_s0 = io_pin_in;
      st_d.io_s1 = st_q.io_s0;
      st_d.core_wr = 1'b0;
      st_d.core_rd = 1'b0;
      // RQ2 extest drives pins from update stage
      st_d.bs_mode = (ins_bs == `JTC_OP_EXTEST);

      // RQ10 boot only after pll lock
      if (!st_q.boot_start && st_q.lock_s[1]) begin
         st_d.boot_start = 1'b1;
         st_d.boot_mode = st_q.boot_s1;
      end

      // RQ5 test reset holds tap logic
      if (!st_q.trst_s[1]) begin
         st_d.tap = TAP_TLR;
         st_d.ir_bs = `JTC_OP_DEVICE_IDENTIFICATION_WORD;
         st_d.ir_ca = `JTC_OP_DEVICE_IDENTIFICATION_WORD;
         st_d.tdo_oe_n = 1'b1;
      end else if (tck_rise) begin
         st_d.tap = jtc_tap_next(st_q.tap, st_q.tms_s[1]);
         unique case (st_q.tap)
            // RQ1 both taps reset to id
            TAP_TLR: begin
               st_d.ir_bs = `JTC_OP_DEVICE_IDENTIFICATION_WORD;
               st_d.ir_ca = `JTC_OP_DEVICE_IDENTIFICATION_WORD;
            end
            TAP_CAP_IR: begin
               st_d.irs_bs = `JTC_IR_CAPTURE;
               st_d.irs_ca = `JTC_IR_CAPTURE;
            end
            TAP_SH_IR: begin
               st_d.irs_bs = {st_q.tdi_s[1], st_q.irs_bs[`JTC_IR_W-1:1]};
               st_d.irs_ca = {st_q.irs_bs[0], st_q.irs_ca[`JTC_IR_W-1:1]};
            end
            TAP_UPD_IR: begin
               st_d.ir_bs = st_q.irs_bs;
               st_d.ir_ca = st_q.irs_ca;
            end
            TAP_CAP_DR: begin
               // RQ2 boundary tap capture
               unique case (ins_bs)
                  `JTC_OP_DEVICE_IDENTIFICATION_WORD: st_d.dr_bs = `JTC_DR_W'(id_word);
                  `JTC_OP_USERCODE: st_d.dr_bs = `JTC_DR_W'(user_word);
                  `JTC_OP_EXTEST, `JTC_OP_SAMPLE: st_d.dr_bs = `JTC_DR_W'(st_q.io_s1);
                  default: st_d.dr_bs = '0;
               endcase
               // RQ6 RQ7 identification and user words
               unique case (ins_ca)
                  `JTC_OP_DEVICE_IDENTIFICATION_WORD: st_d.dr_ca = `JTC_DR_W'(id_word);
                  `JTC_OP_USERCODE: st_d.dr_ca = `JTC_DR_W'(user_word);
                  `JTC_OP_CORE: begin
                     st_d.dr_ca = {st_q.core_sel, core_rdata_in};
                     st_d.core_rd = 1'b1;
                  end
                  default: st_d.dr_ca = '0;
               endcase
            end
            TAP_SH_DR: begin
               st_d.dr_bs = jtc_shift(st_q.dr_bs, st_q.tdi_s[1], jtc_dr_len(ins_bs));
               st_d.dr_ca = jtc_shift(st_q.dr_ca, st_q.dr_bs[0], jtc_dr_len(ins_ca));
            end
            TAP_UPD_DR: begin
               if (ins_bs == `JTC_OP_EXTEST || ins_bs == `JTC_OP_SAMPLE) begin
                  st_d.bs_pin = st_q.dr_bs[NUM_IO-1:0];
               end
               // RQ3 core access, otp gated by its own lock
               if (ins_ca == `JTC_OP_CORE) begin
                  st_d.core_sel = st_q.dr_ca[33:32];
                  st_d.core_wdata = st_q.dr_ca[31:0];
                  st_d.core_wr = !(st_q.dr_ca[33:32] == `JTC_TGT_OTP &&
                                   sec_word[`JTC_SEC_OTP_DIS]);
               end
            end
            default: begin
            end
         endcase
      end else if (tck_fall) begin
         st_d.tdo = (st_q.tap == TAP_SH_IR) ? st_q.irs_ca[0] : st_q.dr_ca[0];
         st_d.tdo_oe_n = !(st_q.tap == TAP_SH_IR || st_q.tap == TAP_SH_DR);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   // RQ9 global reset acts without clock
   always_ff @(posedge ref_clk_in or negedge glob_rst_n_in) begin
      if (!glob_rst_n_in) begin
         st_q <= ST_RST;
      end else if (reset_in) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign tdo_out = st_q.tdo;
   assign tdo_oe_n_out = st_q.tdo_oe_n;
   assign bs_mode_out = st_q.bs_mode;
   assign bs_pin_out = st_q.bs_pin;
   assign core_wr_out = st_q.core_wr;
   assign core_rd_out = st_q.core_rd;
   assign core_sel_out = st_q.core_sel;
   assign core_wdata_out = st_q.core_wdata;
   assign boot_start_out = st_q.boot_start;
   assign boot_mode_out = st_q.boot_mode;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in || !glob_rst_n_in);

   logic cap_dr_edge;
   assign cap_dr_edge = tck_rise && st_q.trst_s[1] && st_q.tap == TAP_CAP_DR;

   a_trst_hold: assert property (!st_q.trst_s[1] |=> st_q.tap == TAP_TLR) // RQ5
      else $error("tap left reset while test reset low");
   a_reset_ir_id: assert property (st_q.tap == TAP_TLR && st_q.trst_s[1] && tck_rise // RQ1
      |=> st_q.ir_bs == `JTC_OP_DEVICE_IDENTIFICATION_WORD && st_q.ir_ca == `JTC_OP_DEVICE_IDENTIFICATION_WORD)
      else $error("instructions not device_identification_word after tap reset");
   a_id_capture: assert property (cap_dr_edge && ins_ca == `JTC_OP_DEVICE_IDENTIFICATION_WORD // RQ6
      |=> st_q.dr_ca[31:0] == id_word && st_q.dr_ca[0])
      else $error("id word not captured");
   a_id_layout: assert property (cap_dr_edge && ins_ca == `JTC_OP_DEVICE_IDENTIFICATION_WORD // RQ14
      |=> st_q.dr_ca[31:28] == ID_VERSION && st_q.dr_ca[27:12] == ID_PART
      && st_q.dr_ca[11:1] == ID_MAKER && st_q.dr_ca[0] == `JTC_ID_ONE)
      else $error("id word layout wrong");
   a_user_capture: assert property (cap_dr_edge && ins_ca == `JTC_OP_USERCODE // RQ7
      |=> st_q.dr_ca[31:22] == sec_word[31:22] && st_q.dr_ca[15:0] == SILICON_REV)
      else $error("user word not captured");
   a_user_zero: assert property (cap_dr_edge && ins_ca == `JTC_OP_USERCODE // RQ8
      && sec_word == `JTC_SEC_RESET |=> st_q.dr_ca[31:22] == 10'h000)
      else $error("user id not zero on blank part");
   a_lock_block: assert property (locked && $past(locked) |-> !core_wr_out && !core_rd_out) // RQ13
      else $error("core access while jtag disabled");
   a_bypass_zero: assert property (cap_dr_edge && ins_bs == `JTC_OP_BYPASS // RQ2
      |=> st_q.dr_bs[0] == 1'b0)
      else $error("bypass capture not zero");
   a_otp_gate: assert property (core_wr_out && core_sel_out == `JTC_TGT_OTP // RQ3
      |-> !$past(sec_word[`JTC_SEC_OTP_DIS]))
      else $error("otp write while otp access disabled");
   a_boot_wait: assert property (!st_q.lock_s[1] && !boot_start_out |=> !boot_start_out) // RQ10
      else $error("boot started before pll lock");

   c_user_read: cover property (cap_dr_edge && ins_ca == `JTC_OP_USERCODE);
   c_core_write: cover property (core_wr_out);
   c_extest: cover property (bs_mode_out ##1 tck_rise && st_q.tap == TAP_UPD_DR);
   c_boot: cover property ($rose(boot_start_out));

endmodule : jtc_tap_chain
`default_nettype wire

// ---- jtc_tap_chain_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module jtc_tap_chain_tb;
   import jtc_pkg::*;
   localparam logic [3:0] VER = 4'h0;
   localparam logic [15:0] PART = 16'h0001;
   localparam logic [10:0] MAKER = 11'h001;
   localparam logic [15:0] SREV = 16'h0001;
   localparam logic [31:0] ID = {VER, PART, MAKER, 1'b1};
   localparam logic [31:0] UC0 = {10'h000, 6'h00, SREV};
   localparam logic [15:0] IO = 16'ha5c3;
   localparam logic [31:0] RD = 32'h1357_9bdf;
   typedef struct {logic [7:0] ir; int n; logic [63:0] din; logic [63:0] exp;} jtc_row_t;

   logic ref_clk_in, reset_in, glob_rst_n, tck, tms, tdi, trst_n, pll_lock, sec_load;
   logic [1:0] boot_mode_in, boot_mode;
   logic [31:0] sec_word, wdata;
   logic tdo, tdo_oe_n, bs_mode, core_wr, core_rd, boot_start;
   logic [15:0] bs_pin;
   jtc_target_t core_sel;
   int errors = 0, checked = 0, wr_cnt = 0, rd_cnt = 0, w0, r0;
   logic [63:0] dout, msk;
   jtc_row_t rows [5];

   jtc_tap_chain #(.NUM_IO(16), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
      .SILICON_REV(SREV)) dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .glob_rst_n_in(glob_rst_n), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
      .trst_n_in(trst_n), .pll_lock_in(pll_lock), .boot_mode_in(boot_mode_in),
      .io_pin_in(IO), .sec_load_in(sec_load), .sec_word_in(sec_word), .core_rdata_in(RD),
      .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .bs_mode_out(bs_mode), .bs_pin_out(bs_pin),
      .core_wr_out(core_wr), .core_rd_out(core_rd), .core_sel_out(core_sel),
      .core_wdata_out(wdata), .boot_start_out(boot_start), .boot_mode_out(boot_mode));

   jtc_dbg_model dbg_u (.ref_clk_in(ref_clk_in), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n),
      .tck_out(tck),
      .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n));

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      if (core_wr === 1'b1) wr_cnt++;
      if (core_rd === 1'b1) rd_cnt++;
   end

   task check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check

   task final_report;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   task ir_dr(input logic [7:0] ir, input int n, input logic [63:0] din);
      dbg_u.scan(1'b1, 8, {56'h0, ir}, dout);
      check(dout[7:0], 8'h11);
      dbg_u.scan(1'b0, n, din, dout);
   endtask : ir_dr

   task load_sec(input logic [31:0] w);
      @(posedge ref_clk_in);
      sec_word <= w;
      sec_load <= 1'b1;
      @(posedge ref_clk_in);
      sec_load <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
   endtask : load_sec

   initial begin
      logic q;
      reset_in = 1'b1;
      glob_rst_n = 1'b0;
      pll_lock = 1'b0;
      boot_mode_in = 2'h2;
      sec_load = 1'b0;
      sec_word = 32'h0;
      rows[0] = '{8'h11, 64, 64'h0, {ID, ID}};
      rows[1] = '{8'h22, 64, 64'h0, {UC0, UC0}};
      rows[2] = '{8'hff, 8, 64'hb5, 64'hd4};
      rows[3] = '{8'h4f, 17, 64'h0, {IO, 1'b0}};
      rows[4] = '{8'hf3, 35, 64'h0, {3'b000, RD}};
      repeat (3) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      // global reset held past 100 ns
      repeat (5) @(posedge ref_clk_in);
      glob_rst_n <= 1'b1;
      repeat (12) @(posedge ref_clk_in);
      check(tdo_oe_n, 1'b1);
      check(boot_start, 1'b0);
      dbg_u.bit_cyc(1'b0, 1'b0, q);
      foreach (rows[i]) begin
         ir_dr(rows[i].ir, rows[i].n, rows[i].din);
         msk = (rows[i].n == 64) ? '1 : ((64'h1 << rows[i].n) - 64'h1);
         check(dout & msk, rows[i].exp);
      end
      for (int t = 0; t < 3; t++) begin
         w0 = wr_cnt;
         ir_dr(8'hf3, 35, {30'h0, t[1:0], 16'hc0de, t[15:0]});
         check(core_sel, t[1:0]);
         check(wdata, {16'hc0de, t[15:0]});
         check(wr_cnt - w0, 1);
      end
      r0 = rd_cnt;
      dbg_u.scan(1'b0, 35, 64'h0, dout);
      check(dout[33:0], {2'h2, RD});
      check(rd_cnt - r0, 1);
      ir_dr(8'h0f, 17, {16'h5a3c, 1'b0});
      check(bs_mode, 1'b1);
      check(bs_pin, 16'h5a3c);
      @(posedge ref_clk_in);
      glob_rst_n <= 1'b0;
      #2;
      check(bs_mode, 1'b0);
      check(bs_pin, 16'h0);
      repeat (8) @(posedge ref_clk_in);
      glob_rst_n <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      check(boot_start, 1'b0);
      pll_lock <= 1'b1;
      for (int k = 0; k < 8 && boot_start !== 1'b1; k++) @(posedge ref_clk_in);
      check(boot_start, 1'b1);
      check(boot_mode, 2'h2);
      dbg_u.set_trst(1'b0);
      repeat (3) @(posedge ref_clk_in);
      w0 = wr_cnt;
      dbg_u.scan(1'b1, 8, 64'hf3, dout);
      dbg_u.scan(1'b0, 35, 64'h7, dout);
      check(dout, 64'h7_ffff_ffff);
      check(wr_cnt - w0, 0);
      check(tdo_oe_n, 1'b1);
      dbg_u.set_trst(1'b1);
      repeat (4) @(posedge ref_clk_in);
      dbg_u.bit_cyc(1'b0, 1'b0, q);
      dbg_u.scan(1'b0, 64, 64'h0, dout);
      check(dout, {ID, ID});
      load_sec({10'h2a5, 22'h0});
      ir_dr(8'h22, 32, 64'h0);
      check(dout[31:0], {10'h2a5, 6'h00, SREV});
      load_sec(32'h1);
      w0 = wr_cnt;
      r0 = rd_cnt;
      ir_dr(8'h03, 8, 64'hb5);
      check(dout[7:0], 8'hd4);
      check(bs_mode, 1'b0);
      check({wr_cnt - w0, rd_cnt - r0}, 64'h0);
      final_report();
   end
endmodule : jtc_tap_chain_tb

`default_nettype wire
